// file: logic/isfrl_regs.sv
// Purpose: Interrupt status two, FIFO state and receive length registers
// Assumes: Event inputs are one-cycle pulses synchronous to clk_sys
// Notes: Function
// Function
// RULE1: Analog flag bit 7 sets on either edge of osc, PLL, field status.
// RULE2: Command-done flag bit 6 sets when a direct command finishes.
// RULE3: Sub-flags: bit 2 CRC, bit 1 length/protocol, bit 0 preamble/overflow.
// RULE4: Status two clears at power-up and while chip enable is low.
// RULE5: A completed read of status clears it and its interrupt.
// RULE6: Interrupt high while any enabled bit set in either status register.
// RULE7: Any error sets summary flag and also the matching sub-flags.
// RULE8: Host may enable only summary error and read only status one; the code lets the host write every enable bit and read status two.
// RULE9: FIFO state bit 7 shows transmission in progress.
// RULE10: FIFO state bit 6 shows reception in progress.
// RULE11: FIFO state bit 5 sets when over 24 bytes loaded.
// RULE12: Five-bit byte count; shows 1Fh after reading an empty FIFO.
// RULE13: No-CRC bit 7 makes reception skip CRC checking.
// RULE14: Raw-FIFO bit 6 passes CRC bytes, swaps header for 2nd-byte irq.
// RULE15: Repeat bit 5 adds byte irqs after bytes four and six.
// RULE16: Auto error-code bit with header set forces length to 41.
// RULE17: Short commands preset length: 16 for 98h-9Ch, 32 for 9Fh.
// RULE18: Host programs other lengths as a 12-bit split value.
// RULE19: Status bits set regardless of enables; enables gate output only.
// RULE20: Reserved bits 5 to 3 of status two read zero.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module isfrl_regs
  import isfrl_pkg::*;
#(
  parameter int FIFO_BYTES = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chip_en,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic osc_good,
  input wire logic pll_good,
  input wire logic field_good,
  input wire logic cmd_done,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_code,
  input wire logic crc_error,
  input wire logic length_error,
  input wire logic protocol_error,
  input wire logic preamble_error,
  input wire logic overflow_error,
  input wire logic tx_busy,
  input wire logic rx_busy,
  input wire logic fifo_load,
  input wire logic fifo_unload,
  input wire logic fifo_clear,
  input wire logic header_bit,
  input wire logic rx_byte_done,
  output logic irq,
  output logic receive_no_crc,
  output logic raw_fifo_second_byte_irq,
  output logic repeat_byte_irq,
  output logic [11:0] rx_expected_bits,
  output logic byte_irq_pulse
);
  // Count field and saturation need a depth of 1 to 30
  if (FIFO_BYTES < 1 || FIFO_BYTES > 30) begin : g_bad_depth
    $error("FIFO_BYTES out of range");
  end
  localparam logic [5:0] FIFO_MAX = 6'(FIFO_BYTES);

  // ==========================================================
  // Bus decode
  logic [7:0] idx;
  logic hit_st2, hit_fifo, hit_up, hit_lo, hit_en2, hit_st1, hit_en1;
  logic rd_done, wr_done, mapped;
  assign idx = avs_address[ADDR_W-1:2];
  assign hit_st2 = idx == IDX_IRQ_STATUS_TWO;
  assign hit_fifo = idx == IDX_FIFO_STATE;
  assign hit_up = idx == IDX_RX_LENGTH_UPPER_OPTS;
  assign hit_lo = idx == IDX_RX_LENGTH_LOWER;
  assign hit_en2 = idx == IDX_ENABLE_TWO;
  assign hit_st1 = idx == IDX_IRQ_STATUS_ONE;
  assign hit_en1 = idx == IDX_ENABLE_ONE;
  assign mapped = hit_st2 | hit_fifo | hit_up | hit_lo | hit_en2 | hit_st1
                  | hit_en1;

  // ==========================================================
  // State
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] resp_reg, resp_next;
  logic [7:0] st2_reg, st2_next;
  logic [7:0] st1_reg, st1_next;
  logic [7:0] en2_reg, en2_next;
  logic [7:0] en1_reg, en1_next;
  logic [7:0] up_reg, up_next;
  logic [7:0] lo_reg, lo_next;
  logic [2:0] ana_reg, ana_next;
  logic [5:0] cnt_reg, cnt_next;
  logic ovfl_reg, ovfl_next;
  logic empty_rd_reg, empty_rd_next;
  logic [2:0] bytes_reg, bytes_next;
  logic hdr_reg, hdr_next;
  logic bi_reg, bi_next;

  assign rd_done = avs_read & ack_reg;
  assign wr_done = avs_write & ack_reg & avs_byteenable[0];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata = rdata_reg;
  assign avs_response = resp_reg;

  // ==========================================================
  // Next-state logic
  logic [2:0] ana_now;
  logic any_err;
  logic [7:0] ev2, ev1, fifo_view;
  logic [5:0] cnt_tmp;
  always_comb begin
    ana_now = {osc_good, pll_good, field_good};
    any_err = crc_error | length_error | protocol_error | preamble_error
              | overflow_error;
    ev2 = 8'h00;
    ev2[BIT_ANA] = |(ana_now ^ ana_reg); // [RULE1]
    ev2[BIT_CMD] = cmd_done; // [RULE2]
    ev2[BIT_CRC] = crc_error; // [RULE3] [RULE7]
    ev2[BIT_LEN] = length_error | protocol_error; // [RULE3] [RULE7]
    ev2[BIT_PRE] = preamble_error | overflow_error; // [RULE3] [RULE7]
    ev1 = 8'h00;
    ev1[BIT_ONE_ERR] = any_err; // [RULE7]
    // Header irq becomes 2nd-byte irq in raw mode
    ev1[BIT_ONE_HDR] = up_reg[BIT_RAW_FIFO] ? byte_irq_pulse
                       : (header_bit & ~hdr_reg); // [RULE14]
    ana_next = ana_now;
    hdr_next = rx_busy & (hdr_reg | header_bit);
    // Read clears, but a new event in the same cycle wins
    st2_next = ((rd_done & hit_st2) ? 8'h00 : st2_reg)
               | (ev2 & STATUS_TWO_MASK); // [RULE5] [RULE19] [RULE20]
    st1_next = ((rd_done & hit_st1) ? 8'h00 : st1_reg) | ev1; // [RULE19]
    en2_next = (wr_done & hit_en2) ? avs_writedata[7:0] : en2_reg;
    en1_next = (wr_done & hit_en1) ? avs_writedata[7:0] : en1_reg;
    up_next = (wr_done & hit_up) ? avs_writedata[7:0] : up_reg;
    lo_next = (wr_done & hit_lo) ? avs_writedata[7:0] : lo_reg;
    // Hardware presets of the expected length
    if (cmd_start && cmd_code >= CMD_SHORT_FIRST
        && cmd_code <= CMD_SHORT_LAST) begin
      up_next[3:0] = LEN_SHORT[11:8]; // [RULE17]
      lo_next = LEN_SHORT[7:0];
    end else if (cmd_start && cmd_code == CMD_LONG) begin
      up_next[3:0] = LEN_LONG[11:8]; // [RULE17]
      lo_next = LEN_LONG[7:0];
    end
    if (up_reg[BIT_AUTO_ERR] && header_bit && rx_busy) begin
      up_next[3:0] = LEN_ERRCODE[11:8]; // [RULE16]
      lo_next = LEN_ERRCODE[7:0];
    end
    // FIFO byte count
    cnt_tmp = cnt_reg;
    empty_rd_next = empty_rd_reg;
    if (fifo_load && cnt_tmp < FIFO_MAX + 6'h01) begin
      cnt_tmp = cnt_tmp + 6'h01;
      empty_rd_next = 1'b0;
    end
    if (fifo_unload) begin
      if (cnt_reg == 6'h00) begin
        empty_rd_next = 1'b1; // [RULE12]
      end else begin
        cnt_tmp = cnt_tmp - 6'h01;
      end
    end
    ovfl_next = ovfl_reg | (fifo_load & (cnt_reg >= FIFO_MAX)); // [RULE11]
    cnt_next = cnt_tmp;
    if (fifo_clear) begin
      cnt_next = 6'h00;
      ovfl_next = 1'b0;
      empty_rd_next = 1'b0;
    end
    // Received byte counter for 2nd/4th/6th byte irqs
    bytes_next = rx_busy ? bytes_reg : 3'h0;
    bi_next = 1'b0;
    if (rx_busy && rx_byte_done && bytes_reg != 3'h7) begin
      bytes_next = bytes_reg + 3'h1;
      bi_next = up_reg[BIT_RAW_FIFO] && (bytes_reg == 3'h1
                || (up_reg[BIT_REPEAT] && (bytes_reg == 3'h3
                || bytes_reg == 3'h5))); // [RULE14] [RULE15]
    end
    fifo_view = 8'h00;
    fifo_view[BIT_TX_BUSY] = tx_busy; // [RULE9]
    fifo_view[BIT_RX_BUSY] = rx_busy; // [RULE10]
    fifo_view[BIT_OVFL] = ovfl_reg; // [RULE11]
    fifo_view[4:0] = empty_rd_reg ? FIFO_EMPTY_READ
                     : cnt_reg[4:0]; // [RULE12]
    ack_next = (avs_read | avs_write) & ~ack_reg;
    rdata_next = 32'h0000_0000;
    resp_next = mapped ? 2'b00 : 2'b10;
    if (avs_read) begin
      unique case (1'b1)
        hit_st2: rdata_next[7:0] = st2_reg & STATUS_TWO_MASK; // [RULE20]
        hit_st1: rdata_next[7:0] = st1_reg;
        hit_fifo: rdata_next[7:0] = fifo_view;
        hit_up: rdata_next[7:0] = up_reg;
        hit_lo: rdata_next[7:0] = lo_reg;
        hit_en2: rdata_next[7:0] = en2_reg;
        hit_en1: rdata_next[7:0] = en1_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st2_reg <= RST_IRQ_TWO; // [RULE4]
      st1_reg <= 8'h00;
      en2_reg <= RST_EN_TWO;
      en1_reg <= RST_EN_ONE;
      up_reg <= RST_RXL_UPPER;
      lo_reg <= RST_RXL_LOWER;
      ana_reg <= 3'h0;
      cnt_reg <= 6'h00;
      ovfl_reg <= 1'b0;
      empty_rd_reg <= 1'b0;
      bytes_reg <= 3'h0;
      hdr_reg <= 1'b0;
      bi_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      resp_reg <= 2'b00;
    end else begin
      st2_reg <= chip_en ? st2_next : RST_IRQ_TWO; // [RULE4]
      st1_reg <= chip_en ? st1_next : 8'h00;
      en2_reg <= en2_next;
      en1_reg <= en1_next;
      up_reg <= up_next;
      lo_reg <= lo_next;
      ana_reg <= ana_next;
      cnt_reg <= cnt_next;
      ovfl_reg <= ovfl_next;
      empty_rd_reg <= empty_rd_next;
      bytes_reg <= bytes_next;
      hdr_reg <= hdr_next;
      bi_reg <= bi_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      resp_reg <= resp_next;
    end
  end

  // ==========================================================
  // Outputs
  assign irq = |(st2_reg & en2_reg) | |(st1_reg & en1_reg); // [RULE6]
  assign receive_no_crc = up_reg[BIT_NO_CRC]; // [RULE13]
  assign raw_fifo_second_byte_irq = up_reg[BIT_RAW_FIFO]; // [RULE14]
  assign repeat_byte_irq = up_reg[BIT_REPEAT]; // [RULE15]
  assign rx_expected_bits = {up_reg[3:0], lo_reg};
  assign byte_irq_pulse = bi_reg;
endmodule // isfrl_regs
`default_nettype wire

// file: shared/isfrl_pkg.sv
// Purpose: Constants for the receive-status register bank
// Assumes: Avalon-MM slave with 32-bit data, one register per word
// Notes: Byte address is four times the register index
package isfrl_pkg;
  // ==========================================================
  // Register indices and address width
  localparam logic [7:0] IDX_IRQ_STATUS_TWO = 8'h38;
  localparam logic [7:0] IDX_FIFO_STATE = 8'h39;
  localparam logic [7:0] IDX_RX_LENGTH_UPPER_OPTS = 8'h3a;
  localparam logic [7:0] IDX_RX_LENGTH_LOWER = 8'h3b;
  localparam logic [7:0] IDX_ENABLE_TWO = 8'h36;
  localparam logic [7:0] IDX_IRQ_STATUS_ONE = 8'h37;
  localparam logic [7:0] IDX_ENABLE_ONE = 8'h35;
  localparam int ADDR_W = 10;
  // ==========================================================
  // Bit positions
  localparam int BIT_ANA = 7;
  localparam int BIT_CMD = 6;
  localparam int BIT_CRC = 2;
  localparam int BIT_LEN = 1;
  localparam int BIT_PRE = 0;
  localparam int BIT_TX_BUSY = 7;
  localparam int BIT_RX_BUSY = 6;
  localparam int BIT_OVFL = 5;
  localparam int BIT_NO_CRC = 7;
  localparam int BIT_RAW_FIFO = 6;
  localparam int BIT_REPEAT = 5;
  localparam int BIT_AUTO_ERR = 4;
  localparam int BIT_ONE_ERR = 4;
  localparam int BIT_ONE_HDR = 3;
  // ==========================================================
  // Reset values and fixed figures
  localparam logic [7:0] RST_IRQ_TWO = 8'h00;
  localparam logic [7:0] RST_RXL_UPPER = 8'h00;
  localparam logic [7:0] RST_RXL_LOWER = 8'h00;
  localparam logic [7:0] RST_EN_TWO = 8'h40;
  localparam logic [7:0] RST_EN_ONE = 8'hfb;
  localparam logic [7:0] STATUS_TWO_MASK = 8'hc7;
  localparam logic [4:0] FIFO_EMPTY_READ = 5'h1f;
  localparam int FIFO_DEPTH = 24;
  localparam logic [11:0] LEN_SHORT = 12'h010;
  localparam logic [11:0] LEN_LONG = 12'h020;
  localparam logic [11:0] LEN_ERRCODE = 12'h029;
  localparam logic [7:0] CMD_SHORT_FIRST = 8'h98;
  localparam logic [7:0] CMD_SHORT_LAST = 8'h9c;
  localparam logic [7:0] CMD_LONG = 8'h9f;
endpackage

// file: verification/isfrl_regs_sva.sv
// Purpose: Port assertions for the receive-status register bank
// Assumes: Bound to isfrl_regs from the bench top file
// Notes: Register index is address bits 9:2
`timescale 1ns/1ps
`default_nettype none
module isfrl_regs_sva
  import isfrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chip_en,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic cmd_done,
  input wire logic cmd_start,
  input wire logic [7:0] cmd_code,
  input wire logic tx_busy,
  input wire logic rx_busy,
  input wire logic irq,
  input wire logic receive_no_crc,
  input wire logic raw_fifo_second_byte_irq,
  input wire logic repeat_byte_irq,
  input wire logic [11:0] rx_expected_bits
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [7:0] idx;
  logic rd_ok;
  logic wr_ok;
  assign idx = avs_address[9:2];
  assign rd_ok = avs_read && !avs_waitrequest;
  assign wr_ok = avs_write && !avs_waitrequest;
  property p_short;
    cmd_start && cmd_code inside {[8'h98:8'h9c]}
    |=> rx_expected_bits == 12'h010;
  endproperty
  a_short: assert property (p_short) else $error("short preset");
  property p_long;
    cmd_start && cmd_code == 8'h9f |=> rx_expected_bits == 12'h020;
  endproperty
  a_long: assert property (p_long) else $error("long preset");
  property p_opts;
    wr_ok && idx == IDX_RX_LENGTH_UPPER_OPTS |=> {receive_no_crc,
      raw_fifo_second_byte_irq, repeat_byte_irq} == $past(avs_writedata[7:5]);
  endproperty
  a_opts: assert property (p_opts) else $error("option bits");
  property p_lower;
    wr_ok && idx == IDX_RX_LENGTH_LOWER
    |=> rx_expected_bits[7:0] == $past(avs_writedata[7:0]);
  endproperty
  a_lower: assert property (p_lower) else $error("length low");
  property p_rsvd;
    rd_ok && idx == IDX_IRQ_STATUS_TWO |-> avs_readdata[5:3] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  property p_tx;
    rd_ok && idx == IDX_FIFO_STATE && $stable(tx_busy)
    |-> avs_readdata[7] == tx_busy;
  endproperty
  a_tx: assert property (p_tx) else $error("tx status");
  property p_rx;
    rd_ok && idx == IDX_FIFO_STATE && $stable(rx_busy)
    |-> avs_readdata[6] == rx_busy;
  endproperty
  a_rx: assert property (p_rx) else $error("rx status");
  property p_cmd;
    cmd_done && chip_en |=> irq;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command irq");
endmodule // isfrl_regs_sva
`default_nettype wire

// file: verification/isfrl_host.sv
// Purpose: Host model that issues register bus transfers
// Assumes: Slave answers through waitrequest
// Notes: Address and data go inverted once released
`timescale 1ns/1ps
`default_nettype none
module isfrl_host
  import isfrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic avs_waitrequest,
  output logic [ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [7:0] d);
    repeat (2) @(posedge clk_sys);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~avs_address;
    avs_writedata <= ~avs_writedata;
  endtask
endmodule // isfrl_host
`default_nettype wire

// file: verification/irq_status_fifo_rx_length_regs_test.sv
// Purpose: Self-checking bench for the receive-status register bank
// Assumes: Host model issues every register access
// Notes: Read results are compared in order from a queue
`timescale 1ns/1ps
`default_nettype none
module irq_status_fifo_rx_length_regs_test
  import isfrl_pkg::*;
;
  logic clk_sys = 1'b0, sys_rst = 1'b1, chip_en = 1'b1;
  logic tx_busy = 1'b0, rx_busy = 1'b0, header_bit = 1'b0;
  logic [2:0] st = 3'h0;
  logic [10:0] ev = 11'h000;
  logic [7:0] cmd_code = 8'h00;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq, byte_irq_pulse;
  logic receive_no_crc, raw_fifo_second_byte_irq, repeat_byte_irq;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [31:0] rs = 32'hbf9eaddb;
  logic [11:0] rx_expected_bits;
  logic [9:0] expq[$];
  logic [9:0] q;
  logic [1:0] avs_response;
  logic [7:0] zr[4] = '{8'h38, 8'h3a, 8'h3b, 8'h10};
  logic [7:0] esub[5] = '{8'h04, 8'h02, 8'h02, 8'h01, 8'h01};
  logic [7:0] cmds[6] = '{8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9f};
  int n_errors = 0, comparisons = 0, n_byte_irq = 0;
  isfrl_regs uut (
    .clk_sys, .sys_rst, .chip_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .avs_response, .osc_good(st[0]),
    .pll_good(st[1]), .field_good(st[2]), .cmd_done(ev[5]),
    .cmd_start(ev[6]), .cmd_code, .crc_error(ev[0]),
    .length_error(ev[1]), .protocol_error(ev[2]),
    .preamble_error(ev[3]), .overflow_error(ev[4]), .tx_busy, .rx_busy,
    .fifo_load(ev[8]), .fifo_unload(ev[9]), .fifo_clear(ev[10]),
    .header_bit, .rx_byte_done(ev[7]), .irq, .receive_no_crc,
    .raw_fifo_second_byte_irq, .repeat_byte_irq, .rx_expected_bits,
    .byte_irq_pulse
  );
  isfrl_host host (
    .clk_sys, .avs_waitrequest, .avs_address, .avs_read, .avs_write,
    .avs_writedata
  );
  always #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    expq.push_back({(i inside {[8'h35:8'h3b]}) ? 2'b00 : 2'b10, e});
    host.xfer(1'b0, i, 8'h00);
  endtask
  task automatic pulse(input int b, input int n);
    @(posedge clk_sys);
    ev[b] <= 1'b1;
    repeat (n) @(posedge clk_sys);
    ev[b] <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // Read monitor and byte interrupt counter
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0) begin
      q = expq.pop_front();
      check(avs_readdata, {24'h0, q[7:0]});
      check(32'(avs_response), 32'(q[9:8]));
    end
    if (byte_irq_pulse === 1'b1)
      n_byte_irq++;
  end
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (zr[i]) rd(zr[i], 8'h00);
    for (int i = 0; i < 3; i++) begin
      st[i] <= 1'b1;
      rd(8'h38, 8'h80);
      st[i] <= 1'b0;
      rd(8'h38, 8'h80);
      rd(8'h38, 8'h00);
    end
    pulse(5, 1);
    @(posedge clk_sys);
    check(32'(irq), 32'h1);
    rd(8'h38, 8'h40);
    repeat (2) @(posedge clk_sys);
    check(32'(irq), 32'h0);
    $display("status two events done");
    host.xfer(1'b1, 8'h35, 8'h00);
    foreach (esub[i]) begin
      pulse(i, 1);
      repeat (2) @(posedge clk_sys);
      check(32'(irq), 32'h0);
      rd(8'h38, esub[i]);
      rd(8'h37, 8'h10);
    end
    host.xfer(1'b1, 8'h35, 8'h10);
    pulse(0, 1);
    repeat (2) @(posedge clk_sys);
    check(32'(irq), 32'h1);
    rd(8'h37, 8'h10);
    repeat (2) @(posedge clk_sys);
    check(32'(irq), 32'h0);
    rd(8'h38, 8'h04);
    $display("errors done");
    {tx_busy, rx_busy} <= 2'b10;
    rd(8'h39, 8'h80);
    {tx_busy, rx_busy} <= 2'b01;
    rd(8'h39, 8'h40);
    rx_busy <= 1'b0;
    pulse(8, 24);
    rd(8'h39, 8'h18);
    pulse(8, 1);
    rd(8'h39, 8'h39);
    pulse(10, 1);
    pulse(9, 1);
    rd(8'h39, 8'h1f);
    $display("fifo state done");
    repeat (4) begin
      r = xs();
      host.xfer(1'b1, 8'h3a, r[7:0] & 8'hef);
      host.xfer(1'b1, 8'h3b, r[15:8]);
      @(posedge clk_sys);
      check(32'({receive_no_crc, raw_fifo_second_byte_irq,
                 repeat_byte_irq}), 32'(r[7:5]));
      check(32'(rx_expected_bits), {20'h0, r[3:0], r[15:8]});
      rd(8'h3a, r[7:0] & 8'hef);
    end
    foreach (cmds[i]) begin
      cmd_code <= cmds[i];
      pulse(6, 1);
      @(posedge clk_sys);
      check(32'(rx_expected_bits),
            cmds[i] == 8'h9f ? 32'h20 : 32'h10);
    end
    host.xfer(1'b1, 8'h3a, 8'h10);
    {header_bit, rx_busy} <= 2'b11;
    repeat (3) @(posedge clk_sys);
    check(32'(rx_expected_bits), 32'h29);
    host.xfer(1'b1, 8'h3a, 8'h60);
    n_byte_irq = 0;
    repeat (6) pulse(7, 1);
    repeat (3) @(posedge clk_sys);
    check(n_byte_irq, 32'h3);
    $display("receive length done");
    pulse(5, 1);
    chip_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chip_en <= 1'b1;
    rd(8'h38, 8'h00);
    $display("chip enable done");
    wrap_up();
  end
endmodule // irq_status_fifo_rx_length_regs_test
bind isfrl_regs isfrl_regs_sva chk (
  .clk_sys, .sys_rst, .chip_en, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest, .avs_readdata, .cmd_done,
  .cmd_start, .cmd_code, .tx_busy, .rx_busy, .irq, .receive_no_crc,
  .raw_fifo_second_byte_irq, .repeat_byte_irq, .rx_expected_bits
);
`default_nettype wire
